//--- dtcu_top.sv
/*
 * Dual timer/counter block with APB register access, line interrupts.
 * Assumes line inputs are asynchronous pins; APB is on clk.
 */
`timescale 1ns/100ps
module dtcu_top (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [7:0]  generalLineIn,
	output logic             generalLineZeroOut,
	output logic             generalLineZeroOe_n,
	output logic             generalLineOneOut,
	output logic             generalLineOneOe_n,
	output logic             irq
);
	localparam int NUNITS = 2;

	logic [7:0]                 lineMeta_reg;
	logic [7:0]                 lineSync_reg;
	logic [7:0]                 linePrev_reg;
	dtcu_pkg::dtcu_ctrl_t       ctrl_reg [NUNITS];
	logic [15:0]                prescale_reg [NUNITS];
	logic [7:0]                 loadLo_reg [NUNITS];
	logic [15:0]                loadVal_reg [NUNITS];
	logic [NUNITS-1:0]          loadStb_reg;
	logic [7:0]                 latchHi_reg [NUNITS];
	dtcu_pkg::dtcu_stat_t       stat [NUNITS];
	logic [NUNITS-1:0]          unitSig;
	logic [dtcu_pkg::IRQ_WIDTH-1:0] irqStat_reg;
	logic [dtcu_pkg::IRQ_WIDTH-1:0] irqMask_reg;
	logic [23:0]                lineMode_reg;
	logic [dtcu_pkg::IRQ_WIDTH-1:0] irqEvent;
	logic [7:0]                 lineEvent;
	logic                       wrAcc;
	logic                       rdAcc;
	logic                       unitHit;
	logic                       unitIdx;
	logic [7:0]                 unitOff;

	// ****************************************************************
	// Pin synchronisers and line edge detection
	// ****************************************************************
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			lineMeta_reg <= 8'h00;
			lineSync_reg <= 8'h00;
			linePrev_reg <= 8'h00;
		end
		else
		begin
			lineMeta_reg <= generalLineIn;
			lineSync_reg <= lineMeta_reg;
			linePrev_reg <= lineSync_reg;
		end
	end

	function automatic logic lineHit(input logic [2:0] mode, input logic cur,
		input logic prev);
		case (dtcu_pkg::dtcu_lmode_t'(mode))
			dtcu_pkg::LM_RISE: lineHit = cur & ~prev;
			dtcu_pkg::LM_FALL: lineHit = ~cur & prev;
			dtcu_pkg::LM_BOTH: lineHit = cur ^ prev;
			dtcu_pkg::LM_HIGH: lineHit = cur;
			dtcu_pkg::LM_LOW:  lineHit = ~cur;
			default:           lineHit = 1'b0;
		endcase
	endfunction

	genvar gl;
	generate
		for (gl = 0; gl < dtcu_pkg::LINE_COUNT; gl++)
		begin : g_line
			assign lineEvent[gl] = lineHit(lineMode_reg[3*gl +: 3], lineSync_reg[gl],
				linePrev_reg[gl]);
		end
	endgenerate

	// ****************************************************************
	// Unit input routing and instances
	// ****************************************************************
	assign unitSig[0] = lineSync_reg[3'd4 + {1'b0, ctrl_reg[0].inSel}];
	assign unitSig[1] = lineSync_reg[4];

	genvar gu;
	generate
		for (gu = 0; gu < NUNITS; gu++)
		begin : g_unit
			dtcu_unit #(
				.WIDTH(16)
			) u_unit (
				.clk     (clk),
				.rst     (rst),
				.ctrl    (ctrl_reg[gu]),
				.loadVal (loadVal_reg[gu]),
				.loadStb (loadStb_reg[gu]),
				.prescale(prescale_reg[gu]),
				.sigIn   (unitSig[gu]),
				.gateIn  (lineSync_reg[5 + gu]),
				.stat    (stat[gu])
			);
		end
	endgenerate

	// Lines zero and one released unless the unit drives them
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			generalLineZeroOut  <= 1'b0;
			generalLineZeroOe_n <= 1'b1;
			generalLineOneOut   <= 1'b0;
			generalLineOneOe_n  <= 1'b1;
		end
		else
		begin
			generalLineZeroOut  <= stat[0].outLevel;
			generalLineZeroOe_n <= ~ctrl_reg[0].outEn;
			generalLineOneOut   <= stat[1].outLevel;
			generalLineOneOe_n  <= ~ctrl_reg[1].outEn;
		end
	end

	// ****************************************************************
	// APB decode
	// ****************************************************************
	assign pready  = 1'b1;
	assign wrAcc   = psel & penable & pwrite;
	assign rdAcc   = psel & ~pwrite;
	assign unitHit = (paddr < 8'h40) && (paddr[4:0] <= dtcu_pkg::OFF_PRESCALE[4:0]);
	assign unitIdx = paddr[5];
	assign unitOff = {3'b000, paddr[4:0]};

	always_comb
	begin
		pslverr = 1'b0;
		if (psel && penable && !unitHit && paddr != dtcu_pkg::OFF_IRQ_STAT
			&& paddr != dtcu_pkg::OFF_IRQ_MASK && paddr != dtcu_pkg::OFF_LINE_MODE
			&& paddr != dtcu_pkg::OFF_LINE_STAT)
			pslverr = 1'b1;
		if (psel && penable && paddr[1:0] != 2'b00)
			pslverr = 1'b1;
	end

	// ****************************************************************
	// Unit registers
	// ****************************************************************
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			for (int i = 0; i < NUNITS; i++)
			begin
				ctrl_reg[i]     <= dtcu_pkg::CTRL_RESET[10:0];
				prescale_reg[i] <= dtcu_pkg::PRESCALE_RST;
				loadLo_reg[i]   <= 8'h00;
				loadVal_reg[i]  <= 16'h0000;
			end
			loadStb_reg <= '0;
		end
		else
		begin
			loadStb_reg <= '0;
			if (wrAcc && unitHit && !pslverr)
			begin
				case (unitOff)
					dtcu_pkg::OFF_CTRL:
						ctrl_reg[unitIdx] <= pwdata[10:0];
					dtcu_pkg::OFF_PRESCALE:
						prescale_reg[unitIdx] <= pwdata[15:0];
					dtcu_pkg::OFF_LOAD_LO:
						loadLo_reg[unitIdx] <= pwdata[7:0];
					dtcu_pkg::OFF_LOAD_HI:
					begin
						loadVal_reg[unitIdx] <= {pwdata[7:0], loadLo_reg[unitIdx]};
						loadStb_reg[unitIdx] <= 1'b1;
					end
					default:
					begin
					end
				endcase
			end
		end
	end

	// Reading the low latch byte snapshots the high byte
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			for (int i = 0; i < NUNITS; i++)
				latchHi_reg[i] <= 8'h00;
		else if (rdAcc && penable && unitHit && unitOff == dtcu_pkg::OFF_LATCH_LO)
			latchHi_reg[unitIdx] <= stat[unitIdx].latch[15:8];
	end

	// ****************************************************************
	// Interrupt status and mask
	// ****************************************************************
	assign irqEvent = {lineEvent, stat[1].evt, stat[0].evt};

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			irqStat_reg  <= '0;
			irqMask_reg  <= '0;
			lineMode_reg <= 24'h00_0000;
		end
		else
		begin
			if (wrAcc && paddr == dtcu_pkg::OFF_IRQ_MASK)
				irqMask_reg <= pwdata[dtcu_pkg::IRQ_WIDTH-1:0];
			if (wrAcc && paddr == dtcu_pkg::OFF_LINE_MODE)
				lineMode_reg <= pwdata[23:0];
			if (wrAcc && paddr == dtcu_pkg::OFF_IRQ_STAT)
				irqStat_reg <= (irqStat_reg & ~pwdata[dtcu_pkg::IRQ_WIDTH-1:0]) | irqEvent;
			else
				irqStat_reg <= irqStat_reg | irqEvent;
		end
	end

	assign irq = |(irqStat_reg & irqMask_reg);

	// ****************************************************************
	// Read data
	// ****************************************************************
	always_comb
	begin
		prdata = 32'h0000_0000;
		if (psel && !pwrite)
		begin
			if (unitHit)
			begin
				case (unitOff)
					dtcu_pkg::OFF_CTRL:     prdata = {21'h0, ctrl_reg[unitIdx]};
					dtcu_pkg::OFF_LOAD_LO:  prdata = {24'h0, loadVal_reg[unitIdx][7:0]};
					dtcu_pkg::OFF_LOAD_HI:  prdata = {24'h0, loadVal_reg[unitIdx][15:8]};
					dtcu_pkg::OFF_LATCH_LO: prdata = {24'h0, stat[unitIdx].latch[7:0]};
					dtcu_pkg::OFF_LATCH_HI: prdata = {24'h0, latchHi_reg[unitIdx]};
					dtcu_pkg::OFF_PRESCALE: prdata = {16'h0, prescale_reg[unitIdx]};
					default:                prdata = 32'h0000_0000;
				endcase
			end
			else
			begin
				case (paddr)
					dtcu_pkg::OFF_IRQ_STAT:  prdata = {22'h0, irqStat_reg};
					dtcu_pkg::OFF_IRQ_MASK:  prdata = {22'h0, irqMask_reg};
					dtcu_pkg::OFF_LINE_MODE: prdata = {8'h0, lineMode_reg};
					dtcu_pkg::OFF_LINE_STAT: prdata = {24'h0, lineSync_reg};
					default:                 prdata = 32'h0000_0000;
				endcase
			end
		end
	end

endmodule // dtcu_top

//--- dtcu_pkg.sv
/*
 * Constants, field layouts and carrier types for the dual timer/counter unit.
 * Assumes an APB master with 32-bit data; registers sit in the low byte lanes.
 */
// Summary of operation
// - Unit has load register, counter, readable latch
// - Load and latch reached one byte each
// - Exactly two independent timer/counter units
// - Unit 1 input lines four-seven, output line zero
// - Unit 2 input line four, output line one
// - Clock and enable from pins or prescaler
// - Each unit picks its own clock rate
// - Pin clock edge: rising, falling or both
// - Output enable only when unit drives line
// - One interrupt per unit, function-chosen condition
// - Any line interrupts on edges or levels
// - Unit 1 input through programmable four-way multiplexer
// - Load and latch are sixteen bits wide
// - Unit 1 input reselectable among four lines
package dtcu_pkg;

	// ****************************************************************
	// Register map (byte addresses, one word per register)
	// ****************************************************************
	localparam logic [7:0] UNIT_STRIDE    = 8'h20;
	localparam logic [7:0] OFF_CTRL       = 8'h00;
	localparam logic [7:0] OFF_LOAD_LO    = 8'h04;
	localparam logic [7:0] OFF_LOAD_HI    = 8'h08;
	localparam logic [7:0] OFF_LATCH_LO   = 8'h0C;
	localparam logic [7:0] OFF_LATCH_HI   = 8'h10;
	localparam logic [7:0] OFF_PRESCALE   = 8'h14;
	localparam logic [7:0] OFF_IRQ_STAT   = 8'h40;
	localparam logic [7:0] OFF_IRQ_MASK   = 8'h44;
	localparam logic [7:0] OFF_LINE_MODE  = 8'h48;
	localparam logic [7:0] OFF_LINE_STAT  = 8'h4C;

	// ****************************************************************
	// Control register fields
	// ****************************************************************
	localparam int CTRL_FUNC_LSB  = 0;
	localparam int CTRL_CLKSRC    = 4;
	localparam int CTRL_EDGE_LSB  = 5;
	localparam int CTRL_ENSRC     = 7;
	localparam int CTRL_INSEL_LSB = 8;
	localparam int CTRL_OUTEN     = 10;
	localparam logic [15:0] CTRL_RESET   = 16'h0000;
	localparam logic [15:0] PRESCALE_RST = 16'h0000;

	localparam int IRQ_UNIT_BITS = 2;
	localparam int LINE_COUNT    = 8;
	localparam int IRQ_WIDTH     = IRQ_UNIT_BITS + LINE_COUNT;

	// Counting functions
	typedef enum logic [3:0] {
		FN_OFF      = 4'h0,
		FN_TOTAL    = 4'h1,
		FN_PERIOD   = 4'h2,
		FN_ONTIME   = 4'h3,
		FN_PULSECNT = 4'h4,
		FN_EDGELOG  = 4'h5,
		FN_QUAD     = 4'h6,
		FN_ONESHOT  = 4'h8,
		FN_FREQ     = 4'h9,
		FN_PWM      = 4'hA
	} dtcu_func_t;

	typedef enum logic [1:0] {
		EDGE_RISE = 2'h0,
		EDGE_FALL = 2'h1,
		EDGE_BOTH = 2'h2
	} dtcu_edge_t;

	// Line interrupt modes
	typedef enum logic [2:0] {
		LM_OFF  = 3'h0,
		LM_RISE = 3'h1,
		LM_FALL = 3'h2,
		LM_BOTH = 3'h3,
		LM_HIGH = 3'h4,
		LM_LOW  = 3'h5
	} dtcu_lmode_t;

	typedef struct packed {
		logic       outEn;
		logic [1:0] inSel;
		logic       enSrc;
		dtcu_edge_t edgeSel;
		logic       clkSrc;
		dtcu_func_t func;
	} dtcu_ctrl_t;

	typedef struct packed {
		logic        evt;
		logic        outLevel;
		logic [15:0] latch;
	} dtcu_stat_t;

endpackage

//--- dtcu_unit.sv
/*
 * One 16-bit timer/counter: load register, counter and latch.
 * Assumes input and gate arrive synchronised to clk.
 */
`timescale 1ns/100ps
module dtcu_unit #(
	parameter int WIDTH = 16
) (
	input  wire logic               clk,
	input  wire logic               rst,
	input  wire dtcu_pkg::dtcu_ctrl_t ctrl,
	input  wire logic [WIDTH-1:0]   loadVal,
	input  wire logic               loadStb,
	input  wire logic [15:0]        prescale,
	input  wire logic               sigIn,
	input  wire logic               gateIn,
	output dtcu_pkg::dtcu_stat_t    stat
);
	logic [WIDTH-1:0] count_reg;
	logic [WIDTH-1:0] reload_reg;
	logic [15:0]      pre_reg;
	logic             sigPrev_reg;
	logic             preTick;
	logic             sigRise;
	logic             sigFall;
	logic             sigEdge;
	logic             tick;
	logic             enable;
	logic             isOut;

	assign sigRise = sigIn & ~sigPrev_reg;
	assign sigFall = ~sigIn & sigPrev_reg;
	assign preTick = (pre_reg == prescale);
	assign isOut   = ctrl.func[3];

	// ****************************************************************
	// Clock and enable selection
	// ****************************************************************
	always_comb
	begin
		case (ctrl.edgeSel)
			dtcu_pkg::EDGE_RISE: sigEdge = sigRise;
			dtcu_pkg::EDGE_FALL: sigEdge = sigFall;
			default:             sigEdge = sigRise | sigFall;
		endcase
		tick   = ctrl.clkSrc ? sigEdge : preTick;
		enable = ctrl.enSrc ? gateIn : 1'b1;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			pre_reg <= 16'h0000;
		else if (preTick)
			pre_reg <= 16'h0000;
		else
			pre_reg <= pre_reg + 16'h0001;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			sigPrev_reg <= 1'b0;
		else
			sigPrev_reg <= sigIn;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			reload_reg <= '0;
		else if (loadStb)
			reload_reg <= loadVal;
	end

	// ****************************************************************
	// Counter, latch, output and event per function
	// ****************************************************************
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			count_reg <= '0;
			stat      <= '0;
		end
		else
		begin
			stat.evt <= 1'b0;
			case (ctrl.func)
				dtcu_pkg::FN_TOTAL, dtcu_pkg::FN_PULSECNT:
				begin
					if (sigEdge && enable)
						count_reg <= count_reg + 1'b1;
					stat.latch <= 16'(count_reg);
					if (sigEdge && enable && count_reg == reload_reg)
						stat.evt <= 1'b1;
				end
				dtcu_pkg::FN_PERIOD, dtcu_pkg::FN_EDGELOG:
				begin
					if (sigEdge)
					begin
						stat.latch <= 16'(count_reg);
						count_reg  <= '0;
						stat.evt   <= 1'b1;
					end
					else if (preTick)
						count_reg <= count_reg + 1'b1;
				end
				dtcu_pkg::FN_ONTIME:
				begin
					if (sigIn && preTick)
						count_reg <= count_reg + 1'b1;
					if (sigFall)
					begin
						stat.latch <= 16'(count_reg);
						count_reg  <= '0;
						stat.evt   <= 1'b1;
					end
				end
				dtcu_pkg::FN_QUAD:
				begin
					if (sigEdge)
						count_reg <= gateIn ? count_reg - 1'b1 : count_reg + 1'b1;
					stat.latch <= 16'(count_reg);
				end
				dtcu_pkg::FN_ONESHOT:
				begin
					if (loadStb)
					begin
						count_reg     <= loadVal;
						stat.outLevel <= (loadVal != '0);
					end
					else if (tick && count_reg != '0)
					begin
						count_reg <= count_reg - 1'b1;
						if (count_reg == 1)
						begin
							stat.outLevel <= 1'b0;
							stat.evt      <= 1'b1;
						end
					end
				end
				dtcu_pkg::FN_FREQ:
				begin
					if (tick && enable)
					begin
						if (count_reg == '0)
						begin
							count_reg     <= reload_reg;
							stat.outLevel <= ~stat.outLevel;
							stat.evt      <= stat.outLevel;
						end
						else
							count_reg <= count_reg - 1'b1;
					end
				end
				dtcu_pkg::FN_PWM:
				begin
					if (tick && enable)
					begin
						count_reg     <= count_reg + 1'b1;
						stat.outLevel <= (count_reg < reload_reg);
						if (count_reg == '1)
							stat.evt <= 1'b1;
					end
				end
				default:
				begin
					count_reg     <= '0;
					stat.outLevel <= 1'b0;
				end
			endcase
			if (!isOut)
				stat.outLevel <= 1'b0;
		end
	end

endmodule // dtcu_unit

//--- dtcu_top_chk.sv
/* Port checker for dtcu_top.
 * Assumes APB on clk and an asynchronous active-high rst. */
`timescale 1ns/100ps
module dtcu_top_chk (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [7:0]  generalLineIn,
	input wire logic        generalLineZeroOut,
	input wire logic        generalLineZeroOe_n,
	input wire logic        generalLineOneOut,
	input wire logic        generalLineOneOe_n,
	input wire logic        irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic acc;
	logic wr;
	logic mapped;
	logic maskZero_reg;
	assign acc = psel && penable;
	assign wr = acc && pwrite;
	assign mapped = paddr[1:0] == 2'h0 && (paddr < 8'h18 || (paddr >= 8'h20 && paddr < 8'h38)
		|| (paddr >= 8'h40 && paddr < 8'h50));
	// Remembers an all-zero interrupt mask
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			maskZero_reg <= 1'b1;
		else if (wr && paddr == 8'h44)
			maskZero_reg <= pwdata[9:0] == 10'h000;
	end
	ready_in_access_a: assert property (acc |-> pready)
		else $error("pready low in access phase");
	err_in_setup_a: assert property (psel && !penable |-> !pslverr)
		else $error("pslverr in setup phase");
	err_unmapped_a: assert property (acc && !mapped |-> pslverr)
		else $error("unmapped access not refused");
	ok_mapped_a: assert property (acc && mapped |-> !pslverr)
		else $error("mapped access refused");
	read_refused_a: assert property (acc && !pwrite && !mapped |-> prdata == 32'h0000_0000)
		else $error("refused read returned data");
	oe_zero_on_a: assert property (wr && paddr == 8'h00 && pwdata[10] |-> ##[1:4] !generalLineZeroOe_n)
		else $error("line zero not driven");
	oe_zero_off_a: assert property (wr && paddr == 8'h00 && !pwdata[10] |-> ##[1:4] generalLineZeroOe_n)
		else $error("line zero not released");
	oe_one_on_a: assert property (wr && paddr == 8'h20 && pwdata[10] |-> ##[1:4] !generalLineOneOe_n)
		else $error("line one not driven");
	irq_masked_a: assert property (maskZero_reg |-> !irq)
		else $error("irq with empty mask");
endmodule // dtcu_top_chk

bind dtcu_top dtcu_top_chk dtcu_top_chk_inst (.clk(clk), .rst(rst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .generalLineIn(generalLineIn),
	.generalLineZeroOut(generalLineZeroOut), .generalLineZeroOe_n(generalLineZeroOe_n),
	.generalLineOneOut(generalLineOneOut), .generalLineOneOe_n(generalLineOneOe_n), .irq(irq));

//--- dtcu_line_model.sv
/* Application-side driver of the eight general lines.
 * Assumes the bench calls its tasks; lines change after rising edges. */
`timescale 1ns/100ps
module dtcu_line_model (
	input  wire logic       clk,
	output logic      [7:0] lines
);
	initial lines = 8'h00;
	task automatic set_line(input int idx, input logic v);
		@(posedge clk);
		lines[idx] <= v;
	endtask
	// Pulses outlast the two-flop synchroniser
	task automatic pulse(input int idx, input int n);
		repeat (n)
		begin
			set_line(idx, 1'b1);
			repeat (3) @(posedge clk);
			set_line(idx, 1'b0);
			repeat (3) @(posedge clk);
		end
	endtask
endmodule // dtcu_line_model

//--- dual_timer_counter_unit_tb_top.sv
/* Self-checking bench for dtcu_top.
 * Assumes the line model drives all eight line inputs. */
`timescale 1ns/100ps
module dual_timer_counter_unit_tb_top;
	logic        clk;
	logic        rst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [7:0]  lineIn;
	logic        zeroOe_n;
	logic        oneOe_n;
	logic        zeroOut;
	logic        oneOut;
	logic        irq;
	int          failures;
	int          checked;
	logic [31:0] rd;
	logic        er;

	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	dtcu_line_model dtcu_line_model_inst (.clk(clk), .lines(lineIn));
	dtcu_top dtcu_top_inst (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .generalLineIn(lineIn), .generalLineZeroOut(zeroOut),
		.generalLineZeroOe_n(zeroOe_n), .generalLineOneOut(oneOut), .generalLineOneOe_n(oneOe_n),
		.irq(irq));

	task automatic tally_and_finish();
		if (failures == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1)
		begin
			failures++;
			tally_and_finish();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wait_for(ref logic s, input logic v);
		for (int n = 0; n < 40 && s !== v; n++)
			@(posedge clk);
		chk({31'h0000_0000, s}, {31'h0000_0000, v});
	endtask

	task automatic rd_latch(input logic [7:0] base, output logic [15:0] v);
		xfer(base + 8'h0C, 1'b0, 32'h0000_0000);
		v[7:0] = rd[7:0];
		xfer(base + 8'h10, 1'b0, 32'h0000_0000);
		v[15:8] = rd[7:0];
	endtask

	task automatic s_reset();
		logic [7:0] okA[4] = '{8'h00, 8'h14, 8'h20, 8'h34};
		logic [7:0] badA[3] = '{8'h18, 8'h50, 8'h02};
		@(posedge clk);
		chk({27'h000_0000, pready, pslverr, zeroOe_n, oneOe_n, irq}, 32'h0000_0016);
		foreach (okA[i])
		begin
			xfer(okA[i], 1'b0, 32'h0000_0000);
			chk(rd, 32'h0000_0000);
		end
		foreach (badA[i])
		begin
			xfer(badA[i], 1'b0, 32'h0000_0000);
			chk({rd[30:0], er}, 32'h0000_0001);
		end
	endtask

	task automatic s_oe();
		xfer(8'h00, 1'b1, 32'h0000_0400);
		wait_for(zeroOe_n, 1'b0);
		chk({31'h0000_0000, oneOe_n}, 32'h0000_0001);
		xfer(8'h20, 1'b1, 32'h0000_0400);
		wait_for(oneOe_n, 1'b0);
		xfer(8'h00, 1'b1, 32'h0000_0000);
		wait_for(zeroOe_n, 1'b1);
		xfer(8'h20, 1'b1, 32'h0000_0000);
		wait_for(oneOe_n, 1'b1);
	endtask

	// Totals from each selectable line and each edge choice
	task automatic s_count();
		logic [15:0] a;
		logic [15:0] b;
		for (int s = 0; s < 4; s++)
			for (int e = 0; e < 3; e++)
			begin
				xfer(8'h00, 1'b1, 32'h0000_0011 | (32'(e) << 5) | (32'(s) << 8));
				rd_latch(8'h00, a);
				dtcu_line_model_inst.pulse(4 + s, 3);
				rd_latch(8'h00, b);
				chk({16'h0000, b - a}, (e == 2) ? 32'h0000_0006 : 32'h0000_0003);
			end
		xfer(8'h20, 1'b1, 32'h0000_0011);
		rd_latch(8'h20, a);
		dtcu_line_model_inst.pulse(5, 3);
		dtcu_line_model_inst.pulse(4, 2);
		rd_latch(8'h20, b);
		chk({16'h0000, b - a}, 32'h0000_0002);
	endtask

	// One-shot pulse of five ticks on each output line
	task automatic s_out();
		xfer(8'h00, 1'b1, 32'h0000_0408);
		xfer(8'h04, 1'b1, 32'h0000_0005);
		xfer(8'h08, 1'b1, 32'h0000_0000);
		wait_for(zeroOut, 1'b1);
		wait_for(zeroOut, 1'b0);
		xfer(8'h20, 1'b1, 32'h0000_0408);
		xfer(8'h24, 1'b1, 32'h0000_0005);
		xfer(8'h28, 1'b1, 32'h0000_0000);
		wait_for(oneOut, 1'b1);
		wait_for(oneOut, 1'b0);
	endtask

	// Line 2 interrupt in every mode but off, then a masked event
	task automatic s_irq();
		logic idle;
		xfer(8'h40, 1'b0, 32'h0000_0000);
		chk(rd & 32'h0000_0003, 32'h0000_0003);
		xfer(8'h44, 1'b1, 32'h0000_0010);
		for (int k = 1; k < 6; k++)
		begin
			idle = (k == 2 || k == 5);
			xfer(8'h48, 1'b1, 32'h0000_0000);
			dtcu_line_model_inst.set_line(2, idle);
			repeat (5) @(posedge clk);
			xfer(8'h48, 1'b1, 32'(k) << 6);
			xfer(8'h40, 1'b1, 32'h0000_03FF);
			@(posedge clk);
			chk({31'h0000_0000, irq}, 32'h0000_0000);
			dtcu_line_model_inst.set_line(2, !idle);
			wait_for(irq, 1'b1);
			xfer(8'h40, 1'b0, 32'h0000_0000);
			chk(rd & 32'h0000_0010, 32'h0000_0010);
			dtcu_line_model_inst.set_line(2, idle);
			repeat (5) @(posedge clk);
			xfer(8'h48, 1'b1, 32'h0000_0000);
			xfer(8'h40, 1'b1, 32'h0000_03FF);
			wait_for(irq, 1'b0);
		end
		dtcu_line_model_inst.set_line(2, 1'b0);
		xfer(8'h44, 1'b1, 32'h0000_0000);
		xfer(8'h48, 1'b1, 32'h0000_0040);
		dtcu_line_model_inst.pulse(2, 1);
		xfer(8'h40, 1'b0, 32'h0000_0000);
		chk(rd & 32'h0000_0010, 32'h0000_0010);
		chk({31'h0000_0000, irq}, 32'h0000_0000);
	endtask

	initial
	begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		failures = 0;
		checked = 0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		s_reset();
		s_oe();
		s_count();
		s_out();
		s_irq();
		tally_and_finish();
	end
endmodule // dual_timer_counter_unit_tb_top
